// File: usart_sync_master_tx_addr_detect.sv
// Purpose: serial port, synchronous master transmit and 9-bit receive
// Assumes: all pins come from outside and are synchronised here
// Notes: registers reached over a one-cycle strobe port
//
// Chosen here: strobed register access.
`timescale 1ns/1ps
module usart_sync_master_tx_addr_detect (
  input wire logic clk,
  input wire logic rst_n,
  input wire usart_pkg::reg_req_t bus,
  output logic [7:0] rd_data,
  input wire logic ck_in,
  output logic ck_out,
  output logic ck_oe,
  input wire logic dt_in,
  output logic dt_out,
  output logic dt_oe,
  output logic irq
);
  import usart_pkg::*;

  logic [7:0] irq_enables;
  logic [7:0] baud_divisor;
  logic serial_port_enable;
  logic receive_ninth_bit_enable;
  logic single_receive_enable;
  logic continuous_receive_enable;
  logic address_detect_enable;
  logic clock_source_select;
  logic transmit_ninth_bit_enable;
  logic transmit_enable;
  logic clocked_mode;
  logic high_speed_baud_select;
  logic transmit_ninth_bit_value;

  logic [7:0] transmit_buffer;
  logic tx_buffer_full;
  logic transmit_irq_flag;
  logic [8:0] transmit_shift_register;
  logic [3:0] bits_left;
  logic shift_register_empty;
  logic dt_q;
  logic tx_load;

  logic [7:0] baud_cnt;
  logic baud_run;
  logic tick;
  logic ck_q;
  logic master_on;
  logic rx_selected;
  logic ck_rise;
  logic ck_fall;

  logic dt_meta;
  logic dt_sync;
  logic dt_prev;
  logic ck_meta;
  logic ck_sync;

  rx_state_t rx_state;
  logic [3:0] os_cnt;
  logic [3:0] rx_bits;
  logic [3:0] last_bit;
  logic [8:0] receive_shift_register;
  logic [8:0] next_rsr;
  logic push_q;
  rx_frame_t push_frame;
  logic single_done;

  rx_frame_t rx_fifo [RX_DEPTH];
  logic [1:0] fifo_count;
  logic rd_ptr;
  logic wr_ptr;
  logic overrun_error_flag;
  logic push_ok;
  logic pop;
  logic receive_irq_flag;
  rx_frame_t head;

  logic wr_tx_buffer;
  logic [7:0] flags_rd;
  logic [7:0] rx_status_rd;
  logic [7:0] tx_status_rd;

  function automatic logic hit(input reg_req_t r, input logic [7:0] a);
    return r.addr == a;
  endfunction

  // the ninth bit lands at the top or shifts out of the way
  function automatic rx_frame_t frame_of(input logic [8:0] sr, input logic nine,
                                         input logic framing_error_flag);
    rx_frame_t f;
    f.framing_error_flag = framing_error_flag;
    if (nine) begin
      f.ninth = sr[8];
      f.data = sr[7:0];
    end else begin
      f.ninth = 1'b0;
      f.data = sr[8:1];
    end
    return f;
  endfunction

  // pin synchronisers; first stage feeds only the second
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dt_meta <= 1'b1;
      dt_sync <= 1'b1;
      dt_prev <= 1'b1;
      ck_meta <= 1'b0;
      ck_sync <= 1'b0;
    end else begin
      dt_meta <= dt_in;
      dt_sync <= dt_meta;
      dt_prev <= dt_sync;
      ck_meta <= ck_in;
      ck_sync <= ck_meta;
    end
  end

  // baud generator
  assign baud_run = transmit_enable | continuous_receive_enable | single_receive_enable;
  assign tick = baud_run && (baud_cnt == baud_divisor);

  always_ff @(posedge clk) begin
    if (!rst_n || !baud_run) begin
      baud_cnt <= '0;
    end else if (tick) begin
      baud_cnt <= '0;
    end else begin
      baud_cnt <= baud_cnt + 8'h01;
    end
  end

  // master shift clock
  assign master_on = serial_port_enable & clocked_mode & clock_source_select;
  assign rx_selected = continuous_receive_enable | single_receive_enable;
  assign ck_rise = tick & ~ck_q & master_on;
  assign ck_fall = tick & ck_q & master_on;

  always_ff @(posedge clk) begin
    if (!rst_n || !master_on || !baud_run) begin
      ck_q <= 1'b0;
    end else if (tick) begin
      ck_q <= ~ck_q;
    end
  end

  assign ck_out = ck_q;
  // clock stays out while receiving with internal clock
  assign ck_oe = master_on & baud_run;
  assign dt_out = dt_q;
  // data pin follows receive enables at once
  assign dt_oe = master_on & transmit_enable & ~rx_selected;

  // transmitter
  assign wr_tx_buffer = bus.wr && hit(bus, ADDR_TX_BUFFER);
  assign shift_register_empty = (bits_left == 4'h0);
  assign tx_load = transmit_enable & tx_buffer_full & shift_register_empty;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      transmit_buffer <= '0;
      tx_buffer_full <= 1'b0;
    end else begin
      if (tx_load) begin
        tx_buffer_full <= 1'b0;
      end
      if (wr_tx_buffer) begin
        transmit_buffer <= bus.wdata;
        tx_buffer_full <= 1'b1;
      end
    end
  end

  // a load sets the flag over the clearing write; the empty-buffer set yields to it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      transmit_irq_flag <= 1'b0;
    end else if (tx_load || (transmit_enable && !tx_buffer_full && !wr_tx_buffer)) begin
      transmit_irq_flag <= 1'b1;
    end else if (wr_tx_buffer) begin
      transmit_irq_flag <= 1'b0;
    end
  end

  // receive enables freeze shifting but keep the word
  always_ff @(posedge clk) begin
    if (!rst_n || !transmit_enable) begin
      transmit_shift_register <= '0;
      bits_left <= '0;
      dt_q <= 1'b0;
    end else if (tx_load) begin
      transmit_shift_register <= {transmit_ninth_bit_value, transmit_buffer};
      bits_left <= transmit_ninth_bit_enable ? FRAME_BITS : WORD_BITS;
    end else if (ck_rise && !rx_selected && !shift_register_empty) begin
      dt_q <= transmit_shift_register[0];
      transmit_shift_register <= {1'b0, transmit_shift_register[8:1]};
      bits_left <= bits_left - 4'h1;
    end
  end

  // receiver, async or synchronous master
  assign next_rsr = {dt_sync, receive_shift_register[8:1]};
  assign last_bit = (receive_ninth_bit_enable ? FRAME_BITS : WORD_BITS) - 4'h1;
  assign single_done = push_q & clocked_mode & single_receive_enable
                       & ~continuous_receive_enable;

  always_ff @(posedge clk) begin
    if (!rst_n || !serial_port_enable || !rx_selected) begin
      rx_state <= RX_IDLE;
      os_cnt <= '0;
      rx_bits <= '0;
      receive_shift_register <= '0;
      push_q <= 1'b0;
      push_frame <= '0;
    end else begin
      push_q <= 1'b0;
      if (clocked_mode) begin
        if (master_on && ck_fall) begin
          receive_shift_register <= next_rsr;
          if (rx_bits == last_bit) begin
            rx_bits <= '0;
            push_q <= 1'b1;
            push_frame <= frame_of(next_rsr, receive_ninth_bit_enable, 1'b0);
          end else begin
            rx_bits <= rx_bits + 4'h1;
          end
        end
      end else if (continuous_receive_enable) begin
        case (rx_state)
          RX_IDLE: begin
            // falling edge only: a low stop bit must not restart a frame
            if (dt_prev && !dt_sync) begin
              rx_state <= RX_START;
              os_cnt <= '0;
            end
          end
          RX_START: begin
            if (tick) begin
              if (os_cnt == OS_MID) begin
                os_cnt <= '0;
                rx_bits <= '0;
                rx_state <= dt_sync ? RX_IDLE : RX_DATA;
              end else begin
                os_cnt <= os_cnt + 4'h1;
              end
            end
          end
          RX_DATA: begin
            if (tick) begin
              if (os_cnt == OS_LAST) begin
                os_cnt <= '0;
                receive_shift_register <= next_rsr;
                if (rx_bits == last_bit) begin
                  rx_state <= RX_STOP;
                end else begin
                  rx_bits <= rx_bits + 4'h1;
                end
              end else begin
                os_cnt <= os_cnt + 4'h1;
              end
            end
          end
          RX_STOP: begin
            if (tick) begin
              if (os_cnt == OS_LAST) begin
                rx_state <= RX_IDLE;
                push_q <= 1'b1;
                push_frame <= frame_of(receive_shift_register,
                                       receive_ninth_bit_enable, ~dt_sync);
              end else begin
                os_cnt <= os_cnt + 4'h1;
              end
            end
          end
          default: begin
            rx_state <= RX_IDLE;
          end
        endcase
      end
    end
  end

  // two-deep receive buffer
  assign push_ok = push_q & ~overrun_error_flag & (fifo_count != RX_DEPTH_COUNT)
                   & ~(address_detect_enable & receive_ninth_bit_enable
                       & ~push_frame.ninth);
  assign pop = bus.rd && hit(bus, ADDR_RX_BUFFER) && (fifo_count != 2'h0);
  assign head = rx_fifo[rd_ptr];
  assign receive_irq_flag = (fifo_count != 2'h0);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fifo_count <= '0;
      rd_ptr <= 1'b0;
      wr_ptr <= 1'b0;
      for (int i = 0; i < RX_DEPTH; i++) begin
        rx_fifo[i] <= '0;
      end
    end else begin
      if (push_ok) begin
        rx_fifo[wr_ptr] <= push_frame;
        wr_ptr <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      fifo_count <= fifo_count + {1'b0, push_ok} - {1'b0, pop};
    end
  end

  // a full buffer loses the word; set wins over the clear
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      overrun_error_flag <= 1'b0;
    end else if (push_q && !overrun_error_flag && fifo_count == RX_DEPTH_COUNT) begin
      overrun_error_flag <= 1'b1;
    end else if (!continuous_receive_enable) begin
      overrun_error_flag <= 1'b0;
    end
  end

  assign irq = (receive_irq_flag & irq_enables[BIT_RX_IRQ])
               | (transmit_irq_flag & irq_enables[BIT_TX_IRQ]);

  // control registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq_enables <= '0;
      baud_divisor <= '0;
      serial_port_enable <= 1'b0;
      receive_ninth_bit_enable <= 1'b0;
      single_receive_enable <= 1'b0;
      continuous_receive_enable <= 1'b0;
      address_detect_enable <= 1'b0;
      clock_source_select <= 1'b0;
      transmit_ninth_bit_enable <= 1'b0;
      transmit_enable <= 1'b0;
      clocked_mode <= 1'b0;
      high_speed_baud_select <= 1'b0;
      transmit_ninth_bit_value <= 1'b0;
    end else begin
      if (single_done) begin
        single_receive_enable <= 1'b0;
      end
      if (bus.wr) begin
        if (hit(bus, ADDR_RX_STATUS)) begin
          serial_port_enable <= bus.wdata[BIT_SERIAL_PORT_ENABLE];
          receive_ninth_bit_enable <= bus.wdata[BIT_RX_NINTH_ENABLE];
          single_receive_enable <= bus.wdata[BIT_SINGLE_RX_ENABLE];
          continuous_receive_enable <= bus.wdata[BIT_CONT_RX_ENABLE];
          address_detect_enable <= bus.wdata[BIT_ADDRESS_DETECT];
        end else if (hit(bus, ADDR_IRQ_ENABLES)) begin
          irq_enables <= bus.wdata;
        end else if (hit(bus, ADDR_TX_STATUS)) begin
          clock_source_select <= bus.wdata[BIT_CLOCK_SOURCE];
          transmit_ninth_bit_enable <= bus.wdata[BIT_TX_NINTH_ENABLE];
          transmit_enable <= bus.wdata[BIT_TRANSMIT_ENABLE];
          clocked_mode <= bus.wdata[BIT_CLOCKED_MODE];
          high_speed_baud_select <= bus.wdata[BIT_HIGH_SPEED_BAUD];
          transmit_ninth_bit_value <= bus.wdata[BIT_TX_NINTH_VALUE];
        end else if (hit(bus, ADDR_BAUD_DIVISOR)) begin
          baud_divisor <= bus.wdata;
        end
      end
    end
  end

  // read words; flag bits ignore writes
  always_comb begin
    flags_rd = '0;
    flags_rd[BIT_RX_IRQ] = receive_irq_flag;
    flags_rd[BIT_TX_IRQ] = transmit_irq_flag;
    rx_status_rd = '0;
    rx_status_rd[BIT_SERIAL_PORT_ENABLE] = serial_port_enable;
    rx_status_rd[BIT_RX_NINTH_ENABLE] = receive_ninth_bit_enable;
    rx_status_rd[BIT_SINGLE_RX_ENABLE] = single_receive_enable;
    rx_status_rd[BIT_CONT_RX_ENABLE] = continuous_receive_enable;
    rx_status_rd[BIT_ADDRESS_DETECT] = address_detect_enable;
    rx_status_rd[BIT_FRAMING_ERROR] = receive_irq_flag & head.framing_error_flag;
    rx_status_rd[BIT_OVERRUN_ERROR] = overrun_error_flag;
    rx_status_rd[BIT_RECEIVED_NINTH] = receive_irq_flag & head.ninth;
    tx_status_rd = '0;
    tx_status_rd[BIT_CLOCK_SOURCE] = clock_source_select;
    tx_status_rd[BIT_TX_NINTH_ENABLE] = transmit_ninth_bit_enable;
    tx_status_rd[BIT_TRANSMIT_ENABLE] = transmit_enable;
    tx_status_rd[BIT_CLOCKED_MODE] = clocked_mode;
    tx_status_rd[BIT_HIGH_SPEED_BAUD] = high_speed_baud_select;
    tx_status_rd[BIT_SHIFT_REG_EMPTY] = shift_register_empty;
    tx_status_rd[BIT_TX_NINTH_VALUE] = transmit_ninth_bit_value;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_data <= '0;
    end else if (bus.rd) begin
      if (hit(bus, ADDR_IRQ_FLAGS)) begin
        rd_data <= flags_rd;
      end else if (hit(bus, ADDR_RX_STATUS)) begin
        rd_data <= rx_status_rd;
      end else if (hit(bus, ADDR_TX_BUFFER)) begin
        rd_data <= transmit_buffer;
      end else if (hit(bus, ADDR_RX_BUFFER)) begin
        rd_data <= receive_irq_flag ? head.data : 8'h00;
      end else if (hit(bus, ADDR_IRQ_ENABLES)) begin
        rd_data <= irq_enables;
      end else if (hit(bus, ADDR_TX_STATUS)) begin
        rd_data <= tx_status_rd;
      end else if (hit(bus, ADDR_BAUD_DIVISOR)) begin
        rd_data <= baud_divisor;
      end else begin
        rd_data <= 8'h00; // shift registers stay unreachable
      end
    end else begin
      rd_data <= 8'h00;
    end
  end

  // clock pin input kept for a later slave mode
  logic ck_unused;
  assign ck_unused = ck_sync;
endmodule // usart_sync_master_tx_addr_detect

// File: usart_pkg.sv
// Purpose: shared constants and types for the serial port block
// Assumes: byte-wide register port, printed offsets used as addresses
// Notes: bit positions are indices into 8-bit registers
package usart_pkg;
  // register addresses
  localparam logic [7:0] ADDR_IRQ_FLAGS = 8'h0C;
  localparam logic [7:0] ADDR_RX_STATUS = 8'h18;
  localparam logic [7:0] ADDR_TX_BUFFER = 8'h19;
  localparam logic [7:0] ADDR_RX_BUFFER = 8'h1A;
  localparam logic [7:0] ADDR_IRQ_ENABLES = 8'h8C;
  localparam logic [7:0] ADDR_TX_STATUS = 8'h98;
  localparam logic [7:0] ADDR_BAUD_DIVISOR = 8'h99;
  // flag and enable register bits
  localparam int BIT_RX_IRQ = 5;
  localparam int BIT_TX_IRQ = 4;
  // receive status and control bits
  localparam int BIT_SERIAL_PORT_ENABLE = 7;
  localparam int BIT_RX_NINTH_ENABLE = 6;
  localparam int BIT_SINGLE_RX_ENABLE = 5;
  localparam int BIT_CONT_RX_ENABLE = 4;
  localparam int BIT_ADDRESS_DETECT = 3;
  localparam int BIT_FRAMING_ERROR = 2;
  localparam int BIT_OVERRUN_ERROR = 1;
  localparam int BIT_RECEIVED_NINTH = 0;
  // transmit status and control bits
  localparam int BIT_CLOCK_SOURCE = 7;
  localparam int BIT_TX_NINTH_ENABLE = 6;
  localparam int BIT_TRANSMIT_ENABLE = 5;
  localparam int BIT_CLOCKED_MODE = 4;
  localparam int BIT_HIGH_SPEED_BAUD = 2;
  localparam int BIT_SHIFT_REG_EMPTY = 1;
  localparam int BIT_TX_NINTH_VALUE = 0;
  // frame lengths, oversampling and receive buffer depth
  localparam logic [3:0] WORD_BITS = 4'h8;
  localparam logic [3:0] FRAME_BITS = 4'h9;
  localparam logic [3:0] OS_MID = 4'h7;
  localparam logic [3:0] OS_LAST = 4'hF;
  localparam int RX_DEPTH = 2;
  localparam logic [1:0] RX_DEPTH_COUNT = 2'h2;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic framing_error_flag;
    logic ninth;
    logic [7:0] data;
  } rx_frame_t;

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
endpackage

// File: usart_chk.sv
// Purpose: port checks for the serial port block
// Assumes: control writes are shadowed from the register port
// Notes: single receive clears itself in clocked mode, so mode checks pause while it is set
`timescale 1ns/1ps
module usart_chk
  import usart_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire usart_pkg::reg_req_t bus,
  input wire logic [7:0] rd_data,
  input wire logic ck_out,
  input wire logic ck_oe,
  input wire logic dt_out,
  input wire logic dt_oe,
  input wire logic irq
);
  logic [7:0] txc;
  logic [7:0] rxc;
  logic [7:0] ien;
  logic mst;
  logic en_any;
  logic mapped;
  assign mst = rxc[7] & txc[4] & txc[7];
  assign en_any = txc[5] | rxc[4] | rxc[5];
  assign mapped = bus.addr inside {ADDR_IRQ_FLAGS, ADDR_RX_STATUS, ADDR_TX_BUFFER,
    ADDR_RX_BUFFER, ADDR_IRQ_ENABLES, ADDR_TX_STATUS, ADDR_BAUD_DIVISOR};
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      txc <= 8'h00;
      rxc <= 8'h00;
      ien <= 8'h00;
    end else if (bus.wr) begin
      if (bus.addr == ADDR_TX_STATUS) txc <= bus.wdata;
      if (bus.addr == ADDR_RX_STATUS) rxc <= bus.wdata;
      if (bus.addr == ADDR_IRQ_ENABLES) ien <= bus.wdata;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_dt_drive_map: assert property (!rxc[5] |-> dt_oe == (mst & txc[5] & !rxc[4]))
    else $error("data enable wrong");
  a_ck_drive_map: assert property (!rxc[5] |-> ck_oe == (mst & (txc[5] | rxc[4])))
    else $error("clock enable wrong");
  a_dt_needs_ck: assert property (dt_oe |-> ck_oe)
    else $error("data driven without clock");
  a_ck_held_idle: assert property (!en_any && !$past(en_any) |-> $stable(ck_out))
    else $error("clock moved with all enables clear");
  a_dt_fall_stable: assert property (dt_oe && $past(dt_oe) && $fell(ck_out) |-> $stable(dt_out))
    else $error("data moved at falling clock");
  a_dt_moves_rise: assert property (dt_oe && $past(dt_oe) && $changed(dt_out) |-> $rose(ck_out))
    else $error("data moved off rising clock");
  a_irq_gated: assert property (ien == 8'h00 |-> !irq)
    else $error("irq with enables clear");
  a_tx_write_clears: assert property (bus.wr && bus.addr == ADDR_TX_BUFFER && ien == 8'h10 |=> !irq)
    else $error("tx flag kept after buffer write");
  a_unmapped_zero: assert property (bus.rd && !mapped |=> rd_data == 8'h00)
    else $error("unmapped read not zero");
endmodule // usart_chk
bind usart_sync_master_tx_addr_detect usart_chk chk (.clk(clk), .rst_n(rst_n), .bus(bus),
  .rd_data(rd_data), .ck_out(ck_out), .ck_oe(ck_oe), .dt_out(dt_out), .dt_oe(dt_oe),
  .irq(irq));

// File: usart_far.sv
// Purpose: far side, a clocked slave and a multi-drop async sender
// Assumes: 80 ns per async bit, data line pulled high when released
// Notes: slave has no framing, so it keeps every bit and the bench searches
`timescale 1ns/1ps
module usart_far (
  input wire logic ck_line,
  input wire logic dt_line,
  output logic drv_en,
  output logic drv_val
);
  logic bits[$];
  initial begin
    drv_en = 1'b0;
    drv_val = 1'b1;
  end
  // sample where data is stable
  always @(negedge ck_line) begin
    bits.push_back(dt_line);
  end
  // ninth bit marks an address frame
  task automatic send(input logic [8:0] w, input logic stop);
    drv_en = 1'b1;
    drv_val = 1'b0;
    #80;
    for (int i = 0; i < 9; i++) begin
      drv_val = w[i];
      #80;
    end
    drv_val = stop;
    #80;
    drv_en = 1'b0;
    #160;
  endtask
endmodule // usart_far

// File: usart_sync_master_tx_addr_detect_test.sv
// Purpose: self-checking bench for the serial port block
// Assumes: divisor 0, so one async bit is 16 clocks, 80 ns
// Notes: tx flag may stay set after abort, so flag reads are masked
`timescale 1ns/1ps
module usart_sync_master_tx_addr_detect_test;
  import usart_pkg::*;
  logic clk;
  logic rst_n;
  reg_req_t bus;
  logic [7:0] rd_data;
  logic ck_out;
  logic ck_oe;
  logic dt_out;
  logic dt_oe;
  logic irq;
  logic drv_en;
  logic drv_val;
  wire ck_line = ck_oe ? ck_out : 1'b0;
  wire dt_line = dt_oe ? dt_out : (drv_en ? drv_val : 1'b1);
  int err_count;
  int cmp_count;
  int cycles;
  usart_sync_master_tx_addr_detect uut (.clk(clk), .rst_n(rst_n), .bus(bus),
    .rd_data(rd_data), .ck_in(ck_line), .ck_out(ck_out), .ck_oe(ck_oe), .dt_in(dt_line),
    .dt_out(dt_out), .dt_oe(dt_oe), .irq(irq));
  usart_far far (.ck_line(ck_line), .dt_line(dt_line), .drv_en(drv_en), .drv_val(drv_val));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      give_verdict();
    end
  end
  task automatic check(input string nm, input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cb(input string nm, input logic got, input logic exp);
    check(nm, {7'h00, got}, {7'h00, exp});
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus <= '0;
    #1;
    d = rd_data;
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e, input string nm);
    logic [7:0] d;
    rd(a, d);
    check(nm, d, e);
  endtask
  task automatic rb(input logic [7:0] a, input int b, input logic e, input string nm);
    logic [7:0] d;
    rd(a, d);
    cb(nm, d[b], e);
  endtask
  // bits seen by the slave hold w, LSB first, with no gap
  function automatic logic has(input logic [15:0] w, input int n);
    int k;
    for (int s = 0; s + n <= far.bits.size(); s++) begin
      k = 0;
      while (k < n && far.bits[s + k] === w[k])
        k++;
      if (k == n) return 1'b1;
    end
    return 1'b0;
  endfunction
  task automatic wait_bits(input logic [15:0] w, input int n);
    int k;
    k = 0;
    while (!has(w, n) && k < 600) begin
      @(posedge clk);
      k++;
    end
    cb("bit stream", has(w, n), 1'b1);
  endtask
  task automatic t_reset();
    logic [7:0] ad [8] = '{ADDR_IRQ_FLAGS, ADDR_RX_STATUS, ADDR_TX_BUFFER, ADDR_RX_BUFFER,
      ADDR_IRQ_ENABLES, ADDR_TX_STATUS, ADDR_BAUD_DIVISOR, 8'h55};
    logic [7:0] ex [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00};
    for (int i = 0; i < 8; i++) begin
      rc(ad[i], ex[i], "reset value");
    end
    wr(ADDR_TX_STATUS, 8'h00);
    rc(ADDR_TX_STATUS, 8'h02, "empty bit");
    wr(ADDR_IRQ_FLAGS, 8'h30);
    rc(ADDR_IRQ_FLAGS, 8'h00, "flags");
  endtask
  task automatic t_sync_tx();
    wr(ADDR_BAUD_DIVISOR, 8'h07);
    wr(ADDR_RX_STATUS, 8'h80);
    wr(ADDR_IRQ_ENABLES, 8'h10);
    wr(ADDR_TX_STATUS, 8'hB0);
    #1;
    cb("ck_oe", ck_oe, 1'b1);
    cb("dt_oe", dt_oe, 1'b1);
    rb(ADDR_IRQ_FLAGS, BIT_TX_IRQ, 1'b1, "tx flag");
    far.bits.delete();
    wr(ADDR_TX_BUFFER, 8'hA5);
    wr(ADDR_TX_BUFFER, 8'h3C);
    rb(ADDR_IRQ_FLAGS, BIT_TX_IRQ, 1'b0, "tx flag full");
    cb("irq full", irq, 1'b0);
    wait_bits(16'h3CA5, 16);
    rb(ADDR_IRQ_FLAGS, BIT_TX_IRQ, 1'b1, "tx flag moved");
    cb("irq moved", irq, 1'b1);
    rc(ADDR_TX_STATUS, 8'hB2, "shift empty");
    wr(ADDR_TX_STATUS, 8'hF0);
    far.bits.delete();
    wr(ADDR_TX_BUFFER, 8'h5A);
    wr(ADDR_TX_STATUS, 8'hF1);
    wait_bits(16'h005A, 9);
  endtask
  task automatic t_abort();
    logic [7:0] d;
    int n;
    wr(ADDR_TX_STATUS, 8'hB0);
    wr(ADDR_TX_BUFFER, 8'h00);
    wr(ADDR_RX_STATUS, 8'hA0);
    #1;
    cb("dt_oe rx", dt_oe, 1'b0);
    cb("ck_oe rx", ck_oe, 1'b1);
    d = 8'hFF;
    n = 0;
    while (d[BIT_SINGLE_RX_ENABLE] !== 1'b0 && n < 200) begin
      rd(ADDR_RX_STATUS, d);
      n++;
    end
    cb("single ends", d[BIT_SINGLE_RX_ENABLE], 1'b0);
    cb("dt_oe back", dt_oe, 1'b1);
    rc(ADDR_RX_BUFFER, 8'hFF, "sync word");
    wr(ADDR_TX_STATUS, 8'h90);
    #1;
    cb("ck_oe off", ck_oe, 1'b0);
    cb("dt_oe off", dt_oe, 1'b0);
    rc(ADDR_TX_STATUS, 8'h92, "tx reset");
  endtask
  task automatic t_addr();
    wr(ADDR_TX_STATUS, 8'h00);
    wr(ADDR_BAUD_DIVISOR, 8'h00);
    wr(ADDR_IRQ_ENABLES, 8'h20);
    wr(ADDR_RX_STATUS, 8'hC8);
    wr(ADDR_RX_STATUS, 8'hD8);
    far.send(9'h055, 1'b1);
    rb(ADDR_IRQ_FLAGS, BIT_RX_IRQ, 1'b0, "data dropped");
    far.send(9'h1A3, 1'b1);
    cb("rx irq", irq, 1'b1);
    rc(ADDR_RX_STATUS, 8'hD9, "addr status");
    rc(ADDR_RX_BUFFER, 8'hA3, "addr byte");
    rb(ADDR_IRQ_FLAGS, BIT_RX_IRQ, 1'b0, "rx drained");
    wr(ADDR_RX_STATUS, 8'hD0);
    far.send(9'h066, 1'b1);
    far.send(9'h177, 1'b0);
    rc(ADDR_RX_STATUS, 8'hD0, "status 1");
    rc(ADDR_RX_BUFFER, 8'h66, "data byte");
    rc(ADDR_RX_STATUS, 8'hD5, "status 2");
    rc(ADDR_RX_BUFFER, 8'h77, "byte 2");
    far.send(9'h011, 1'b1);
    far.send(9'h022, 1'b1);
    far.send(9'h033, 1'b1);
    rc(ADDR_RX_STATUS, 8'hD2, "overrun");
    wr(ADDR_RX_STATUS, 8'hC0);
    rc(ADDR_RX_STATUS, 8'hC0, "overrun cleared");
    rc(ADDR_RX_BUFFER, 8'h11, "kept 1");
    rc(ADDR_RX_BUFFER, 8'h22, "kept 2");
  endtask
  initial begin
    rst_n = 1'b0;
    bus = '0;
    err_count = 0;
    cmp_count = 0;
    cycles = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_sync_tx();
    t_abort();
    t_addr();
    give_verdict();
  end
endmodule // usart_sync_master_tx_addr_detect_test
